/* File: inc/top_cfg_pkg.sv */
package top_cfg_pkg;

   // register byte offsets on the serial bus
   localparam logic [7:0] OFF_CFG1 = 8'h0a;
   localparam logic [7:0] OFF_CFG2 = 8'h0b;
   localparam logic [7:0] OFF_CFG3 = 8'h0c;

   // reset values
   localparam logic [7:0] RST_CFG1 = 8'h89;
   localparam logic [7:0] RST_CFG2 = 8'hce;
   localparam logic [7:0] RST_CFG3 = 8'h01;
   localparam logic [7:0] RST_NONE = 8'h00;

   // field positions in input_source_protect_cfg
   localparam int SRC_LSB  = 4;
   localparam int OVP_BIT  = 2;
   localparam int INLK_LSB = 0;

   // field positions in temp_and_rail_lockout_cfg
   localparam int RLK_LSB  = 6;
   localparam int TSD_LSB  = 2;
   localparam int WARN_LSB = 0;

   // field position in operating_mode_cfg
   localparam int MODE_LSB = 3;

   // bytes of one bus transaction
   localparam logic [1:0] PH_ADDR = 2'h0;
   localparam logic [1:0] PH_PTR  = 2'h1;
   localparam logic [1:0] PH_DATA = 2'h2;

   // bits in one byte
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // idle level of the bus lines
   localparam logic [1:0] BUS_IDLE = 2'h3;

endpackage

/* File: core/bus_sync.sv */
`timescale 1ns/1ps
module bus_sync #(
   parameter int           W   = 2,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         nrst_i,
   // asynchronous level in, settled level out
   input  wire logic [W-1:0] d_i,
   output logic [W-1:0]      q_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_s;

   sync_s r;
   sync_s next_r;

   // only a bit on which the second and third stages agree is passed on
   always_comb begin
      next_r    = r;
      next_r.s1 = d_i;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < W; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            next_r.q[i] = r.s2[i];
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r <= {RST, RST, RST, RST};
      end else begin
         r <= next_r;
      end
   end

   assign q_o = r.q;

endmodule

/* File: core/mode_pick.sv */
`timescale 1ns/1ps
module mode_pick (
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       nrst_i,
   // mode sources
   input  wire logic       pin_mode_source_enable_i,
   input  wire logic [1:0] pin_mode_i,
   input  wire logic [1:0] reg_mode_i,
   // applied mode code
   output logic [1:0]      op_mode_o
);

   typedef struct packed {
      logic [1:0] mode;
   } mode_s;

   mode_s r;
   mode_s next_r;

   always_comb begin
      next_r = r;
      if (pin_mode_source_enable_i) begin
         next_r.mode = pin_mode_i;  // [R7]
      end else begin
         next_r.mode = reg_mode_i;  // [R7] [R8]
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign op_mode_o = r.mode;

endmodule

/* File: core/pmic_top_config_regs.sv */
`timescale 1ns/1ps
// Function
// R1 - two-bit rail source: 00 either/adapter first, 01 battery, 10 adapter, 11 off; reset 00
// R2 - adapter over-voltage select, 0 is 5.50 V, 1 is 6.0 V; reset 0
// R3 - adapter lockout select 2.9/3.1/3.3/3.5 V for 00..11; reset 01
// R4 - rail lockout select in bits 7:6, 2.4 V to 2.7 V; reset 11
// R5 - thermal shutdown select 95..125 degrees, 111 reserved; reset 011
// R6 - die warning select in bits 1:0, 75..90 degrees; reset 10
// R7 - mode code comes from register bits or the two mode pins
// R8 - with pin selection off, mode equals register bits high:low; both reset 0
// R9 - all three registers read and write over the bus and read back
// R10 - host avoids the reserved shutdown code and the rail disconnect code
module pmic_top_config_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary bus address
) (
   // clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       nrst_i,
   // serial bus pins, data line open drain
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   // mode selection
   input  wire logic [1:0] mode_select_pin_i,
   input  wire logic       pin_mode_source_enable_i,
   // select codes to the analog blocks
   output logic [1:0]      system_rail_source_select_o,
   output logic            input_overvoltage_threshold_o,
   output logic [1:0]      input_lockout_threshold_o,
   output logic [1:0]      rail_lockout_threshold_o,
   output logic [2:0]      thermal_shutdown_threshold_o,
   output logic [1:0]      die_temp_warning_threshold_o,
   output logic [1:0]      op_mode_o
);

   typedef enum logic [2:0] {
      st_idle,
      st_rx,
      st_ack,
      st_tx,
      st_tx_ack,
      st_tx_next
   } bus_state_e;

   typedef struct packed {
      bus_state_e st;
      logic       scl_q;
      logic       sda_q;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [1:0] phase;
      logic       rw;
      logic [7:0] ptr;
      logic [7:0] cfg1;
      logic [7:0] cfg2;
      logic [7:0] cfg3;
      logic       sda_oe_n;
   } bank_s;

   function automatic logic [7:0] rd_mux(input logic [7:0] p,
                                         input logic [7:0] c1,
                                         input logic [7:0] c2,
                                         input logic [7:0] c3);
      logic [7:0] b;
      b = top_cfg_pkg::RST_NONE;
      if (p == top_cfg_pkg::OFF_CFG1) begin
         b = c1;
      end else if (p == top_cfg_pkg::OFF_CFG2) begin
         b = c2;
      end else if (p == top_cfg_pkg::OFF_CFG3) begin
         b = c3;
      end
      return b;
   endfunction

   bank_s      r;
   bank_s      next_r;
   logic       scl_f;
   logic       sda_f;
   logic [1:0] mode_pins;
   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;
   logic       wr_en;
   logic [7:0] wr_ptr;
   logic [7:0] wr_byte;
   logic       load_tx;
   logic [7:0] rd_byte;

   bus_sync #(
      .W   (2),
      .RST (top_cfg_pkg::BUS_IDLE)
   ) u_bus_sync (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .d_i       ({scl_i, sda_i}),
      .q_o       ({scl_f, sda_f})
   );

   bus_sync #(
      .W   (2),
      .RST (2'h0)
   ) u_pin_sync (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .d_i       (mode_select_pin_i),
      .q_o       (mode_pins)
   );

   mode_pick u_mode_pick (
      .sys_clk_i                (sys_clk_i),
      .nrst_i                   (nrst_i),
      .pin_mode_source_enable_i (pin_mode_source_enable_i),
      .pin_mode_i               (mode_pins),
      .reg_mode_i               (r.cfg3[top_cfg_pkg::MODE_LSB +: 2]),
      .op_mode_o                (op_mode_o)
   );

   assign scl_rise  = scl_f & ~r.scl_q;
   assign scl_fall  = ~scl_f & r.scl_q;
   assign bus_start = scl_f & r.scl_q & r.sda_q & ~sda_f;
   assign bus_stop  = scl_f & r.scl_q & ~r.sda_q & sda_f;
   assign rd_byte   = rd_mux(r.ptr, r.cfg1, r.cfg2, r.cfg3);  // [R9]

   always_comb begin
      next_r       = r;
      next_r.scl_q = scl_f;
      next_r.sda_q = sda_f;
      wr_en        = 1'h0;
      wr_ptr       = r.ptr;
      wr_byte      = r.shreg;
      load_tx      = 1'h0;
      // a start or stop abandons any transfer, even in mid byte
      if (bus_start) begin
         next_r.st       = st_rx;
         next_r.bitcnt   = 4'h0;
         next_r.phase    = top_cfg_pkg::PH_ADDR;
         next_r.sda_oe_n = 1'h1;
      end else if (bus_stop) begin
         next_r.st       = st_idle;
         next_r.sda_oe_n = 1'h1;
      end else begin
         unique case (r.st)
            st_idle: begin
            end
            st_rx: begin
               if (scl_rise && r.bitcnt != top_cfg_pkg::BYTE_BITS) begin
                  next_r.shreg  = {r.shreg[6:0], sda_f};
                  next_r.bitcnt = r.bitcnt + 4'h1;
               end else if (scl_fall && r.bitcnt == top_cfg_pkg::BYTE_BITS) begin
                  next_r.bitcnt   = 4'h0;
                  next_r.st       = st_ack;
                  next_r.sda_oe_n = 1'h0;
                  unique case (r.phase)
                     top_cfg_pkg::PH_ADDR: begin
                        next_r.rw    = r.shreg[0];
                        next_r.phase = top_cfg_pkg::PH_PTR;
                        if (r.shreg[7:1] != DEV_ADDR) begin
                           next_r.st       = st_idle;
                           next_r.sda_oe_n = 1'h1;
                        end
                     end
                     top_cfg_pkg::PH_PTR: begin
                        next_r.ptr   = r.shreg;
                        next_r.phase = top_cfg_pkg::PH_DATA;
                     end
                     default: begin
                        wr_en      = 1'h1;
                        next_r.ptr = r.ptr + 8'h01;
                     end
                  endcase
               end
            end
            st_ack: begin
               if (scl_fall) begin
                  next_r.sda_oe_n = 1'h1;
                  if (r.rw) begin
                     load_tx = 1'h1;
                  end else begin
                     next_r.st = st_rx;
                  end
               end
            end
            st_tx: begin
               if (scl_fall) begin
                  if (r.bitcnt == top_cfg_pkg::BYTE_BITS) begin
                     next_r.sda_oe_n = 1'h1;
                     next_r.st       = st_tx_ack;
                  end else begin
                     next_r.sda_oe_n = r.shreg[7];
                     next_r.shreg    = {r.shreg[6:0], 1'h0};
                     next_r.bitcnt   = r.bitcnt + 4'h1;
                  end
               end
            end
            st_tx_ack: begin
               // a not-acknowledge ends the read; the bus waits for stop
               if (scl_rise) begin
                  next_r.st = sda_f ? st_idle : st_tx_next;
               end
            end
            st_tx_next: begin
               if (scl_fall) begin
                  load_tx = 1'h1;
               end
            end
            default: begin
               next_r.st       = st_idle;
               next_r.sda_oe_n = 1'h1;
            end
         endcase
      end
      // unmapped pointers are acknowledged but store nothing
      if (wr_en) begin
         if (wr_ptr == top_cfg_pkg::OFF_CFG1) begin
            next_r.cfg1 = wr_byte;  // [R1] [R2] [R3] [R9]
         end else if (wr_ptr == top_cfg_pkg::OFF_CFG2) begin
            next_r.cfg2 = wr_byte;  // [R4] [R5] [R6] [R9]
         end else if (wr_ptr == top_cfg_pkg::OFF_CFG3) begin
            next_r.cfg3 = wr_byte;  // [R8] [R9]
         end
      end
      if (load_tx) begin
         next_r.sda_oe_n = rd_byte[7];  // [R9]
         next_r.shreg    = {rd_byte[6:0], 1'h0};
         next_r.bitcnt   = 4'h1;
         next_r.ptr      = r.ptr + 8'h01;
         next_r.st       = st_tx;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         r          <= '0;
         r.st       <= st_idle;
         r.scl_q    <= 1'h1;
         r.sda_q    <= 1'h1;
         r.phase    <= top_cfg_pkg::PH_ADDR;
         r.cfg1     <= top_cfg_pkg::RST_CFG1;  // [R1] [R2] [R3]
         r.cfg2     <= top_cfg_pkg::RST_CFG2;  // [R4] [R5] [R6]
         r.cfg3     <= top_cfg_pkg::RST_CFG3;  // [R8]
         r.sda_oe_n <= 1'h1;
      end else begin
         r <= next_r;
      end
   end

   // the line is only ever pulled low; the enable decides
   assign sda_o                         = 1'h0;
   assign sda_oe_n_o                    = r.sda_oe_n;
   assign system_rail_source_select_o   = r.cfg1[top_cfg_pkg::SRC_LSB +: 2];
   assign input_overvoltage_threshold_o = r.cfg1[top_cfg_pkg::OVP_BIT];
   assign input_lockout_threshold_o     = r.cfg1[top_cfg_pkg::INLK_LSB +: 2];
   assign rail_lockout_threshold_o      = r.cfg2[top_cfg_pkg::RLK_LSB +: 2];
   assign thermal_shutdown_threshold_o  = r.cfg2[top_cfg_pkg::TSD_LSB +: 3];
   assign die_temp_warning_threshold_o  = r.cfg2[top_cfg_pkg::WARN_LSB +: 2];

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_write_to(logic [7:0] off);
      wr_en && wr_ptr == off;
   endsequence

   property p_rail_source;
      s_write_to(top_cfg_pkg::OFF_CFG1) |=> system_rail_source_select_o == $past(wr_byte[5:4]);
   endproperty
   a_rail_source: assert property (p_rail_source) else $error("rail source not updated"); // [R1]

   property p_ovp;
      s_write_to(top_cfg_pkg::OFF_CFG1) |=> input_overvoltage_threshold_o == $past(wr_byte[2]);
   endproperty
   a_ovp: assert property (p_ovp) else $error("overvoltage select not updated"); // [R2]

   property p_in_lockout;
      s_write_to(top_cfg_pkg::OFF_CFG1) |=> input_lockout_threshold_o == $past(wr_byte[1:0]);
   endproperty
   a_in_lockout: assert property (p_in_lockout) else $error("input lockout not updated"); // [R3]

   property p_rail_lockout;
      s_write_to(top_cfg_pkg::OFF_CFG2) |=> rail_lockout_threshold_o == $past(wr_byte[7:6]);
   endproperty
   a_rail_lockout: assert property (p_rail_lockout) else $error("rail lockout not updated"); // [R4]

   property p_shutdown;
      s_write_to(top_cfg_pkg::OFF_CFG2) |=> thermal_shutdown_threshold_o == $past(wr_byte[4:2]);
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("shutdown select not updated"); // [R5]

   property p_warning;
      s_write_to(top_cfg_pkg::OFF_CFG2) |=> die_temp_warning_threshold_o == $past(wr_byte[1:0]);
   endproperty
   a_warning: assert property (p_warning) else $error("warning select not updated"); // [R6]

   property p_pin_mode;
      pin_mode_source_enable_i |=> op_mode_o == $past(mode_pins);
   endproperty
   a_pin_mode: assert property (p_pin_mode) else $error("mode not taken from pins"); // [R7]

   // the mode stage registers the register bits seen one cycle earlier
   property p_reg_mode;
      !pin_mode_source_enable_i ##1 !pin_mode_source_enable_i
         |=> op_mode_o == $past(r.cfg3[top_cfg_pkg::MODE_LSB +: 2]);
   endproperty
   a_reg_mode: assert property (p_reg_mode) else $error("mode not taken from register"); // [R8]

   property p_reset_vals;
      $rose(nrst_i) |-> r.cfg1 == top_cfg_pkg::RST_CFG1 && r.cfg2 == top_cfg_pkg::RST_CFG2
                        && r.cfg3 == top_cfg_pkg::RST_CFG3 && op_mode_o == 2'h0;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("wrong reset value"); // [R1]

   // compared against the register picked by the pointer, not against the read mux
   property p_readback;
      load_tx |=> {sda_oe_n_o, r.shreg[7:1]} == $past(
         (r.ptr == top_cfg_pkg::OFF_CFG1) ? r.cfg1 :
         (r.ptr == top_cfg_pkg::OFF_CFG2) ? r.cfg2 :
         (r.ptr == top_cfg_pkg::OFF_CFG3) ? r.cfg3 : top_cfg_pkg::RST_NONE);
   endproperty
   a_readback: assert property (p_readback) else $error("read byte differs from register"); // [R9]

   property p_hold;
      !wr_en |=> r.cfg1 == $past(r.cfg1) && r.cfg2 == $past(r.cfg2) && r.cfg3 == $past(r.cfg3);
   endproperty
   a_hold: assert property (p_hold) else $error("register changed without write"); // [R9]

endmodule

/* File: verification/i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model (
   // clock
   input  wire logic sys_clk_i,
   // bus wires, data line as seen on the wire
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // twelve system clocks per half period keeps well clear of the synchronizer delay
   localparam int HALF = 12;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask

   // also serves as repeated start, entered with the clock low
   task automatic start();
      sda_o = 1'b1;
      hold(HALF);
      scl_o = 1'b1;
      hold(HALF);
      sda_o = 1'b0;
      hold(HALF);
      scl_o = 1'b0;
   endtask

   task automatic stop();
      sda_o = 1'b0;
      hold(HALF);
      scl_o = 1'b1;
      hold(HALF);
      sda_o = 1'b1;
      hold(HALF);
   endtask

   task automatic bit_xfer(input logic b, output logic r);
      sda_o = b;
      hold(HALF);
      scl_o = 1'b1;
      hold(HALF);
      r = sda_i;
      scl_o = 1'b0;
   endtask

   // msb first, then the acknowledge slot; a released line reads the pull-up
   task automatic byte_xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(d[i], q[i]);
      end
      bit_xfer(ack_in, ack);
   endtask
endmodule

/* File: verification/test_pmic_top_config_regs.sv */
`timescale 1ns/1ps
module test_pmic_top_config_regs;
   typedef logic [7:0] byte_q_t [$];
   localparam logic [6:0] ADDR = 7'h2a;

   logic       sys_clk;
   logic       nrst;
   logic       scl;
   logic       sda_host;
   logic       sda_line;
   logic       sda_drv;
   logic       sda_oe_n;
   logic [1:0] pins;
   logic       pin_en;
   logic [1:0] src;
   logic       ovp;
   logic [1:0] inlk;
   logic [1:0] rlk;
   logic [2:0] tsd;
   logic [1:0] warn;
   logic [1:0] op_mode;
   int         mdl [3];
   int         fail_count;
   int         tests_run;

   // open drain with pull-up: low if either party pulls
   assign sda_line = sda_host & (sda_oe_n | sda_drv);

   i2c_host_model host (
      .sys_clk_i (sys_clk),
      .sda_i     (sda_line),
      .scl_o     (scl),
      .sda_o     (sda_host)
   );

   pmic_top_config_regs #(.DEV_ADDR(ADDR)) uut (
      .sys_clk_i                     (sys_clk),
      .nrst_i                        (nrst),
      .scl_i                         (scl),
      .sda_i                         (sda_line),
      .sda_o                         (sda_drv),
      .sda_oe_n_o                    (sda_oe_n),
      .mode_select_pin_i             (pins),
      .pin_mode_source_enable_i      (pin_en),
      .system_rail_source_select_o   (src),
      .input_overvoltage_threshold_o (ovp),
      .input_lockout_threshold_o     (inlk),
      .rail_lockout_threshold_o      (rlk),
      .thermal_shutdown_threshold_o  (tsd),
      .die_temp_warning_threshold_o  (warn),
      .op_mode_o                     (op_mode)
   );

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [7:0] model_rd(input int p);
      return (p >= 10 && p <= 12) ? 8'(mdl[p - 10]) : 8'h00;
   endfunction

   task automatic send(input logic [7:0] b);
      logic [7:0] q;
      logic       ack;
      host.byte_xfer(b, 1'b1, q, ack);
      chk("ack", 8'h00, {7'h00, ack});
   endtask

   task automatic write_regs(input logic [7:0] ptr, input byte_q_t d);
      host.start();
      send({ADDR, 1'b0});
      send(ptr);
      foreach (d[i]) begin
         send(d[i]);
         if (ptr + i >= 10 && ptr + i <= 12) begin
            mdl[ptr + i - 10] = d[i];
         end
      end
      host.stop();
   endtask

   task automatic read_regs(input logic [7:0] ptr, input int n);
      logic [7:0] q;
      logic       ack;
      host.start();
      send({ADDR, 1'b0});
      send(ptr);
      host.start();
      send({ADDR, 1'b1});
      for (int i = 0; i < n; i++) begin
         host.byte_xfer(8'hff, logic'(i == n - 1), q, ack);
         chk("read data", model_rd(ptr + i), q);
      end
      host.stop();
   endtask

   task automatic chk_outs();
      logic [1:0] m;
      m = pin_en ? pins : mdl[2][4:3];
      chk("source", {6'h00, mdl[0][5:4]}, {6'h00, src});
      chk("overvoltage", {7'h00, mdl[0][2]}, {7'h00, ovp});
      chk("input lockout", {6'h00, mdl[0][1:0]}, {6'h00, inlk});
      chk("rail lockout", {6'h00, mdl[1][7:6]}, {6'h00, rlk});
      chk("shutdown", {5'h00, mdl[1][4:2]}, {5'h00, tsd});
      chk("warning", {6'h00, mdl[1][1:0]}, {6'h00, warn});
      chk("mode", {6'h00, m}, {6'h00, op_mode});
   endtask

   initial begin
      repeat (80000) @(posedge sys_clk);
      fail_count++;
      $display("ERROR watchdog expected done seen timeout");
      tally_and_finish();
   end

   initial begin
      byte_q_t d;
      nrst = 1'b0;
      pins = 2'h0;
      pin_en = 1'b0;
      mdl = '{top_cfg_pkg::RST_CFG1, top_cfg_pkg::RST_CFG2, top_cfg_pkg::RST_CFG3};
      void'($urandom(15));
      repeat (16) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk_outs();
      read_regs(top_cfg_pkg::OFF_CFG1, 3);
      for (int k = 0; k < 8; k++) begin
         d = {};
         repeat (3) d.push_back(8'($urandom));
         // keep clear of the rail disconnect and reserved shutdown codes
         if (d[0][5:4] == 2'h3) d[0][5] = 1'b0;
         if (d[1][4:2] == 3'h7) d[1][2] = 1'b0;
         d[2][4:3] = 2'(k);
         pin_en = k[2];
         pins = ~2'(k);
         write_regs(top_cfg_pkg::OFF_CFG1, d);
         repeat (8) @(negedge sys_clk);
         chk_outs();
         read_regs(k[0] ? top_cfg_pkg::OFF_CFG2 : top_cfg_pkg::OFF_CFG1, 3);
      end
      // second byte lands on an unmapped place and must be dropped
      write_regs(top_cfg_pkg::OFF_CFG3, '{8'($urandom) & 8'he7, 8'h5a});
      pin_en = 1'b0;
      repeat (8) @(negedge sys_clk);
      chk_outs();
      read_regs(top_cfg_pkg::OFF_CFG2, 3);
      tally_and_finish();
   end
endmodule
